// >>> tacp_checker.sv
/*
  Port checker for tacp_parser: attribute commands, text and menu.
  Assumes one pclk domain; bound to every tacp_parser at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tacp_defines.svh"
module tacp_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TACP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic menu_request,
  input wire logic menu_shown,
  input wire logic mode_maintenance,
  input wire logic terminal_clear,
  input wire logic text_valid,
  input wire logic attr_inverse,
  input wire logic attr_flash,
  input wire logic attr_flash_inverse,
  input wire logic attr_half_size,
  input wire logic [2:0] attr_enlarge
);
  logic esc_q;
  logic par_q;
  wire logic wr = psel & penable & pwrite & (paddr == `TACP_OFF_DATA);
  wire logic ab = psel & penable & pwrite & (paddr == `TACP_OFF_CTRL) &
    pwdata[`TACP_CTRL_ABORT];
  wire logic [7:0] b = pwdata[7:0];
  wire logic cmd = wr & esc_q;
  wire logic [5:0] att = {attr_inverse, attr_flash, attr_half_size,
    attr_enlarge};
  ////////////////////////////////////////////////////////////////////////
  // Shadow parser state; an abort write drops it as in the design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      esc_q <= 1'b0;
      par_q <= 1'b0;
    end else if (ab) begin
      esc_q <= 1'b0;
      par_q <= 1'b0;
    end else if (wr) begin
      esc_q <= !esc_q && !par_q && b == `TACP_ESC;
      par_q <= esc_q && (b == `TACP_CMD_MENU || b == `TACP_CMD_SIZE ||
        b == `TACP_CMD_ENL);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_inv_on;
    cmd && b == `TACP_CMD_INV_ON |=> attr_inverse && $stable(attr_flash);
  endproperty
  a_inv_on: assert property (p_inv_on) else $error("inverse not set");
  property p_inv_off;
    cmd && b == `TACP_CMD_INV_OFF |=> !attr_inverse && $stable(attr_flash);
  endproperty
  a_inv_off: assert property (p_inv_off) else $error("inverse kept");
  property p_fl_on;
    cmd && b == `TACP_CMD_FL_ON |=> attr_flash && $stable(attr_inverse);
  endproperty
  a_fl_on: assert property (p_fl_on) else $error("flash not set");
  property p_fl_off;
    cmd && b == `TACP_CMD_FL_OFF |=> !attr_flash && $stable(attr_inverse);
  endproperty
  a_fl_off: assert property (p_fl_off) else $error("flash kept");
  property p_normal;
    cmd && b == `TACP_CMD_NORMAL |=> !attr_flash && !attr_inverse;
  endproperty
  a_normal: assert property (p_normal) else $error("normal failed");
  property p_clr;
    cmd && b == `TACP_CMD_CLEAR |=> terminal_clear ##1 !terminal_clear;
  endproperty
  a_clr: assert property (p_clr) else $error("clear pulse wrong");
  property p_ign;
    cmd && !(b inside {[8'h21:8'h26], 8'h29, 8'h2a, 8'h57}) |=> $stable(att);
  endproperty
  a_ign: assert property (p_ign) else $error("bad command acted");
  property p_text;
    wr && !esc_q && !par_q && b != `TACP_ESC |=> text_valid && $stable(att);
  endproperty
  a_text: assert property (p_text) else $error("text path wrong");
  property p_flinv;
    attr_flash_inverse == (attr_inverse && attr_flash);
  endproperty
  a_flinv: assert property (p_flinv) else $error("flash inverse");
  property p_mode;
    $changed(mode_maintenance) |-> $past(menu_shown) || menu_shown;
  endproperty
  a_mode: assert property (p_mode) else $error("mode without menu");
  property p_menu;
    $rose(menu_shown) |-> $past(menu_request, 2);
  endproperty
  a_menu: assert property (p_menu) else $error("menu unasked");
  // Main scenarios reached
  c_inv: cover property (cmd && b == `TACP_CMD_INV_ON);
  c_clr: cover property (terminal_clear);
  c_mnt: cover property (menu_shown && mode_maintenance);
endmodule : tacp_checker
bind tacp_parser tacp_checker i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .menu_request, .menu_shown, .mode_maintenance,
  .terminal_clear, .text_valid, .attr_inverse, .attr_flash,
  .attr_flash_inverse, .attr_half_size, .attr_enlarge);
`default_nettype wire

// >>> tacp_defines.svh
/*
  Constants for the terminal attribute command parser: command codes,
  parameter codes, APB register offsets and field positions.
  Assumes it is included by bare name from files that need the values.
*/
`ifndef TACP_DEFINES_SVH
`define TACP_DEFINES_SVH

// Command stream codes
`define TACP_ESC 8'h1b
`define TACP_CMD_MENU 8'h57
`define TACP_CMD_CLEAR 8'h26
`define TACP_CMD_SIZE 8'h29
`define TACP_CMD_ENL 8'h2a
`define TACP_CMD_NORMAL 8'h21
`define TACP_CMD_INV_ON 8'h22
`define TACP_CMD_INV_OFF 8'h23
`define TACP_CMD_FL_ON 8'h24
`define TACP_CMD_FL_OFF 8'h25

// Parameter byte codes
`define TACP_PAR_0 8'h30
`define TACP_PAR_1 8'h31
`define TACP_PAR_ENL_MAX 8'h35
`define TACP_ENL_NONE 3'h0

// APB register byte offsets
`define TACP_ADDR_W 12
`define TACP_OFF_DATA 12'h000
`define TACP_OFF_CTRL 12'h004
`define TACP_OFF_STAT 12'h008
`define TACP_OFF_CNT 12'h00c

// Control register bits
`define TACP_CTRL_SWITCH 0
`define TACP_CTRL_ABORT 1

// Status register bits
`define TACP_ST_INV 0
`define TACP_ST_FL 1
`define TACP_ST_FLINV 2
`define TACP_ST_HALF 3
`define TACP_ST_ENL_LO 4
`define TACP_ST_ENL_HI 6
`define TACP_ST_PERMIT 8
`define TACP_ST_MENU 9
`define TACP_ST_MAINT 10
`define TACP_ST_BUSY 11

// Counter register fields
`define TACP_CNT_CLR_LO 0
`define TACP_CNT_IGN_LO 8

// Edges after reset release until the synchronised switch is loaded;
// two fill the synchroniser, the third takes the pin's real level
`define TACP_LOAD_WAIT 2'h3

`endif

// >>> tacp_host.sv
/*
  Host model: feeds escape command bytes over APB as the bus master.
  Assumes pready may stall; pready still low after 64 access edges sets hung.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tacp_defines.svh"
module tacp_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [`TACP_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata
);
  logic hung;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    hung = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One transfer; request held until pready is seen high, for at most 64 access edges
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (pready !== 1'b1) hung = 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task put(input logic [7:0] v);
    logic [31:0] q;
    logic e;
    xfer(1'b1, `TACP_OFF_DATA, {24'h0, v}, q, e);
  endtask : put
  // Three-byte command with its parameter code
  task cmd3(input logic [7:0] c, input logic [7:0] p);
    put(`TACP_ESC);
    put(c);
    put(p);
  endtask : cmd3
endmodule : tacp_host
`default_nettype wire

// >>> tacp_parser.sv
/*
  Terminal attribute command parser. Software feeds the host's command
  byte stream through an APB data register; escape sequences update the
  sticky display attributes, other bytes pass out as text tagged with
  the attributes in force. Also holds the system menu permission.
  Assumes a single pclk domain, APB master behaviour per the bus spec,
  and slow level pins for the menu switch and operator selections.
*/
`timescale 1ns/1ps
`default_nettype none

`include "tacp_defines.svh"

// Notes on behaviour
// - Menu command parameter 30h permits system menu, 31h suppresses it.
// - While menu permitted, operator may pick transmit or maintenance mode.
// - After reset, menu permission reloads from the menu permit switch.
// - Attributes stay in force until cancelled or replaced.
// - Escape then 26h erases all terminal text and graphics.
// - Registered screen stays underneath; only changed elements redraw.
// - Escape 29h then 30h gives 16x8 cell, 31h gives 8x8 cell.
// - Size applies to later characters until screen switch; default normal.
// - Enlargement scales later output until screen switch; default none.
// - Escape 21h clears inverse and flashing together.
// - Escape 22h sets inverse only.
// - Escape 23h clears inverse only, flashing kept.
// - Escape 24h sets flashing only.
// - Escape 25h clears flashing only, inverse kept.
// - Inverse plus flashing together renders as flashing inverse.
// - Screen shown or switched resets inverse and flashing to plain.
module tacp_parser (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TACP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic menu_permit_switch,
  input wire logic menu_request,
  input wire logic sel_transmit,
  input wire logic sel_maintenance,
  output logic menu_shown,
  output logic mode_maintenance,
  output logic terminal_clear,
  output logic text_valid,
  output logic [7:0] text_byte,
  output logic attr_inverse,
  output logic attr_flash,
  output logic attr_flash_inverse,
  output logic attr_half_size,
  output logic [2:0] attr_enlarge
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [3:0] pins_s;
  logic switch_s;
  logic menu_req_s;
  logic sel_tx_s;
  logic sel_mt_s;

  // Switch and operator keys are asynchronous to pclk
  tacp_sync #(
    .WIDTH(4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({menu_permit_switch, menu_request, sel_transmit,
      sel_maintenance}),
    .sync_out(pins_s)
  );

  assign switch_s = pins_s[3];
  assign menu_req_s = pins_s[2];
  assign sel_tx_s = pins_s[1];
  assign sel_mt_s = pins_s[0];

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  logic setup_rd;
  logic acc_wr;
  logic mapped;
  logic wr_data;
  logic wr_ctrl;
  logic [7:0] byte_in;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  // Only the four word offsets answer
  always_comb begin
    unique case (paddr)
      `TACP_OFF_DATA: mapped = 1'b1;
      `TACP_OFF_CTRL: mapped = 1'b1;
      `TACP_OFF_STAT: mapped = 1'b1;
      `TACP_OFF_CNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Error answer for unmapped offsets, during the access phase only
  assign pslverr = psel & penable & ~mapped;

  // Read data is latched in setup so it comes from a flip-flop
  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc_wr = psel & penable & pwrite;
  assign wr_data = acc_wr & (paddr == `TACP_OFF_DATA);
  assign wr_ctrl = acc_wr & (paddr == `TACP_OFF_CTRL);
  assign byte_in = pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // State

  tacp_pkg::tacp_regs_t s_q;
  tacp_pkg::tacp_regs_t s_d;

  logic ld_done;
  logic is_enl_par;
  logic is_bin_par;
  logic [31:0] stat_word;
  logic [31:0] cnt_word;

  // Switch sample is trusted once the synchroniser has filled
  assign ld_done = (s_q.ld_cnt == `TACP_LOAD_WAIT);

  // Parameter range checks
  assign is_bin_par = (byte_in == `TACP_PAR_0) | (byte_in == `TACP_PAR_1);
  assign is_enl_par = (byte_in >= `TACP_PAR_0) &
    (byte_in <= `TACP_PAR_ENL_MAX);

  // Status word assembly
  always_comb begin
    stat_word = '0;
    stat_word[`TACP_ST_INV] = s_q.inv;
    stat_word[`TACP_ST_FL] = s_q.flash;
    stat_word[`TACP_ST_FLINV] = s_q.inv & s_q.flash;
    stat_word[`TACP_ST_HALF] = s_q.half;
    stat_word[`TACP_ST_ENL_HI:`TACP_ST_ENL_LO] = s_q.enl;
    stat_word[`TACP_ST_PERMIT] = s_q.permit;
    stat_word[`TACP_ST_MENU] = s_q.menu;
    stat_word[`TACP_ST_MAINT] = s_q.maint;
    stat_word[`TACP_ST_BUSY] = (s_q.st != tacp_pkg::TACP_IDLE);
  end

  // Event counters word
  always_comb begin
    cnt_word = '0;
    cnt_word[`TACP_CNT_CLR_LO +: 8] = s_q.n_clr;
    cnt_word[`TACP_CNT_IGN_LO +: 8] = s_q.n_ign;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.clr = 1'b0;
    s_d.txt_valid = 1'b0;

    // Read data capture in the setup phase
    if (setup_rd) begin
      unique case (paddr)
        `TACP_OFF_STAT: s_d.prdata = stat_word;
        `TACP_OFF_CNT: s_d.prdata = cnt_word;
        default: s_d.prdata = '0;
      endcase
    end

    // Permission reload from the switch after reset
    if (!ld_done) begin
      s_d.ld_cnt = s_q.ld_cnt + 2'h1;
      s_d.permit = switch_s;
    end

    // Menu visible only while permitted; selection only while visible
    s_d.menu = s_q.permit & menu_req_s & ld_done;
    if (s_q.menu) begin
      if (sel_mt_s) begin
        s_d.maint = 1'b1;
      end else if (sel_tx_s) begin
        s_d.maint = 1'b0;
      end
    end

    // Screen switch returns the size, scale and attributes to defaults
    if (wr_ctrl && pwdata[`TACP_CTRL_SWITCH]) begin
      s_d.inv = 1'b0;
      s_d.flash = 1'b0;
      s_d.half = 1'b0;
      s_d.enl = `TACP_ENL_NONE;
    end

    // Abort drops a half-received sequence
    if (wr_ctrl && pwdata[`TACP_CTRL_ABORT]) begin
      s_d.st = tacp_pkg::TACP_IDLE;
    end

    // Command byte stream
    if (wr_data) begin
      unique case (s_q.st)
        tacp_pkg::TACP_IDLE: begin
          if (byte_in == `TACP_ESC) begin
            s_d.st = tacp_pkg::TACP_ESC_SEEN;
          end else begin
            // Text carries whatever attributes are in force
            s_d.txt_valid = 1'b1;
            s_d.txt_byte = byte_in;
          end
        end
        tacp_pkg::TACP_ESC_SEEN: begin
          s_d.st = tacp_pkg::TACP_IDLE;
          s_d.cmd = byte_in;
          unique case (byte_in)
            `TACP_CMD_MENU: s_d.st = tacp_pkg::TACP_PARAM;
            `TACP_CMD_SIZE: s_d.st = tacp_pkg::TACP_PARAM;
            `TACP_CMD_ENL: s_d.st = tacp_pkg::TACP_PARAM;
            `TACP_CMD_CLEAR: begin
              // Only the terminal layer is wiped, the screen stays
              s_d.clr = 1'b1;
              s_d.n_clr = s_q.n_clr + 8'h01;
            end
            `TACP_CMD_NORMAL: begin
              s_d.inv = 1'b0;
              s_d.flash = 1'b0;
            end
            `TACP_CMD_INV_ON: s_d.inv = 1'b1;
            `TACP_CMD_INV_OFF: s_d.inv = 1'b0;
            `TACP_CMD_FL_ON: s_d.flash = 1'b1;
            `TACP_CMD_FL_OFF: s_d.flash = 1'b0;
            default: begin
              s_d.n_ign = s_q.n_ign + 8'h01;
            end
          endcase
        end
        tacp_pkg::TACP_PARAM: begin
          s_d.st = tacp_pkg::TACP_IDLE;
          if (s_q.cmd == `TACP_CMD_MENU && is_bin_par) begin
            s_d.permit = (byte_in == `TACP_PAR_0);
          end else if (s_q.cmd == `TACP_CMD_SIZE && is_bin_par) begin
            s_d.half = (byte_in == `TACP_PAR_1);
          end else if (s_q.cmd == `TACP_CMD_ENL && is_enl_par) begin
            s_d.enl = byte_in[2:0];
          end else begin
            // Out of range parameter leaves every setting alone
            s_d.n_ign = s_q.n_ign + 8'h01;
          end
        end
        default: begin
          s_d.st = tacp_pkg::TACP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Constants only under reset; the switch is taken after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.st <= tacp_pkg::TACP_IDLE;
      s_q.cmd <= 8'h00;
      s_q.inv <= 1'b0;
      s_q.flash <= 1'b0;
      s_q.half <= 1'b0;
      s_q.enl <= `TACP_ENL_NONE;
      s_q.permit <= 1'b0;
      s_q.ld_cnt <= 2'h0;
      s_q.menu <= 1'b0;
      s_q.maint <= 1'b0;
      s_q.clr <= 1'b0;
      s_q.txt_valid <= 1'b0;
      s_q.txt_byte <= 8'h00;
      s_q.n_clr <= 8'h00;
      s_q.n_ign <= 8'h00;
      s_q.prdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops except attr_flash_inverse, an AND of two of them

  assign prdata = s_q.prdata;
  assign menu_shown = s_q.menu;
  assign mode_maintenance = s_q.maint;
  assign terminal_clear = s_q.clr;
  assign text_valid = s_q.txt_valid;
  assign text_byte = s_q.txt_byte;
  assign attr_inverse = s_q.inv;
  assign attr_flash = s_q.flash;
  assign attr_flash_inverse = s_q.inv & s_q.flash;
  assign attr_half_size = s_q.half;
  assign attr_enlarge = s_q.enl;

endmodule : tacp_parser

`default_nettype wire

// >>> tacp_pkg.sv
/*
  Types shared by the terminal attribute command parser.
  Assumes tacp_defines.svh supplies the numeric constants.
*/
`default_nettype none

package tacp_pkg;

  // Parser states, Gray coded along idle -> escape -> parameter
  typedef enum logic [1:0] {
    TACP_IDLE = 2'h0,
    TACP_ESC_SEEN = 2'h1,
    TACP_PARAM = 2'h3
  } tacp_state_t;

  // Whole register state of the parser
  typedef struct packed {
    tacp_state_t st;
    logic [7:0] cmd;
    logic inv;
    logic flash;
    logic half;
    logic [2:0] enl;
    logic permit;
    logic [1:0] ld_cnt;
    logic menu;
    logic maint;
    logic clr;
    logic txt_valid;
    logic [7:0] txt_byte;
    logic [7:0] n_clr;
    logic [7:0] n_ign;
    logic [31:0] prdata;
  } tacp_regs_t;

endpackage : tacp_pkg

`default_nettype wire

// >>> tacp_sync.sv
/*
  Two-stage synchroniser for a group of slow level inputs.
  Assumes the inputs are quasi-static pins from outside the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module tacp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : tacp_sync

`default_nettype wire

// >>> terminal_attribute_command_parser_test.sv
/*
  Self-checking bench for tacp_parser driven by the tacp_host model.
  Assumes zero-wait APB and the register map of tacp_defines.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tacp_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module terminal_attribute_command_parser_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [`TACP_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic menu_permit_switch, menu_request, sel_transmit, sel_maintenance;
  logic menu_shown, mode_maintenance, terminal_clear, text_valid, e;
  logic attr_inverse, attr_flash, attr_flash_inverse, attr_half_size;
  logic [7:0] text_byte;
  logic [2:0] attr_enlarge;
  int n_mismatch, n_checks, k;
  tacp_parser i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .menu_permit_switch, .menu_request,
    .sel_transmit, .sel_maintenance, .menu_shown, .mode_maintenance,
    .terminal_clear, .text_valid, .text_byte, .attr_inverse, .attr_flash,
    .attr_flash_inverse, .attr_half_size, .attr_enlarge);
  tacp_host i_host (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task rst(input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    menu_permit_switch <= s;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : rst
  task rd(input logic [11:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  task esc(input logic [7:0] c);
    i_host.put(`TACP_ESC);
    i_host.put(c);
    @(negedge pclk);
  endtask : esc
  task t_menu;
    rst(1'b1);
    rd(`TACP_OFF_STAT);
    `CHK(q[8], 1'b1)
    i_host.cmd3(8'h57, 8'h31);
    menu_request <= 1'b1;
    repeat (6) @(negedge pclk);
    `CHK(menu_shown, 1'b0)
    i_host.cmd3(8'h57, 8'h30);
    for (k = 0; k < 10 && menu_shown !== 1'b1; k++) @(negedge pclk);
    `CHK(menu_shown, 1'b1)
    @(posedge pclk) sel_maintenance <= 1'b1;
    repeat (6) @(negedge pclk);
    `CHK(mode_maintenance, 1'b1)
    @(posedge pclk) sel_maintenance <= 1'b0;
    sel_transmit <= 1'b1;
    repeat (6) @(negedge pclk);
    `CHK(mode_maintenance, 1'b0)
    @(posedge pclk) sel_transmit <= 1'b0;
    menu_request <= 1'b0;
    rst(1'b0);
    rd(`TACP_OFF_STAT);
    `CHK(q[8], 1'b0)
    $display("menu test done");
  endtask : t_menu
  // Attribute commands in an order that visits all four inverse/flash states
  task t_attr;
    static logic [7:0] c [7] = '{8'h22, 8'h24, 8'h23, 8'h22, 8'h25, 8'h24,
      8'h21};
    static logic [1:0] x [7] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h3, 2'h0};
    for (int i = 0; i < 7; i++) begin
      esc(c[i]);
      `CHK({attr_inverse, attr_flash}, x[i])
      `CHK(attr_flash_inverse, &x[i])
    end
    esc(8'h22);
    i_host.put(8'h41);
    @(negedge pclk);
    `CHK({text_valid, text_byte, attr_inverse}, 10'h283)
    $display("attribute test done");
  endtask : t_attr
  task t_size;
    i_host.cmd3(8'h29, 8'h31);
    i_host.put(8'h41);
    @(negedge pclk);
    `CHK(attr_half_size, 1'b1)
    i_host.cmd3(8'h29, 8'h30);
    @(negedge pclk);
    `CHK(attr_half_size, 1'b0)
    for (int i = 0; i < 6; i++) begin
      i_host.cmd3(8'h2a, 8'(8'h30 + i));
      @(negedge pclk);
      `CHK(attr_enlarge, 3'(i))
    end
    i_host.cmd3(8'h2a, 8'h36);
    i_host.cmd3(8'h29, 8'h32);
    esc(8'h7f);
    `CHK({attr_half_size, attr_enlarge}, 4'h5)
    rd(`TACP_OFF_CNT);
    `CHK(q[15:8], 8'h03)
    $display("size test done");
  endtask : t_size
  task t_clear;
    esc(`TACP_CMD_CLEAR);
    `CHK(terminal_clear, 1'b1)
    @(negedge pclk);
    `CHK({terminal_clear, attr_enlarge}, 4'h5)
    rd(`TACP_OFF_CNT);
    `CHK(q[7:0], 8'h01)
    $display("clear test done");
  endtask : t_clear
  // Screen switch drops every attribute; then an unmapped read
  task t_switch;
    i_host.cmd3(8'h29, 8'h31);
    esc(8'h24);
    i_host.xfer(1'b1, `TACP_OFF_CTRL, 32'h1, q, e);
    @(negedge pclk);
    `CHK({attr_inverse, attr_flash}, 2'h0)
    `CHK({attr_half_size, attr_enlarge}, 4'h0)
    rd(12'h010);
    `CHK(e, 1'b1)
    $display("switch test done");
  endtask : t_switch
  // Abort drops a pending escape, so the next byte passes as text
  task t_abort;
    i_host.put(`TACP_ESC);
    i_host.xfer(1'b1, `TACP_OFF_CTRL, 32'h2, q, e);
    i_host.put(8'h22);
    @(negedge pclk);
    `CHK({text_valid, text_byte, attr_inverse}, 10'h244)
    $display("abort test done");
  endtask : t_abort
  task close_out;
    if (i_host.hung) n_mismatch++;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  initial begin
    presetn = 1'b0;
    menu_permit_switch = 1'b0;
    menu_request = 1'b0;
    sel_transmit = 1'b0;
    sel_maintenance = 1'b0;
    t_menu();
    t_attr();
    t_size();
    t_clear();
    t_switch();
    t_abort();
    close_out();
  end
endmodule : terminal_attribute_command_parser_test
`default_nettype wire
